/* core/mmcr_consts.svh */
// Constants of the memory-map configuration register bank
`ifndef MMCR_CONSTS_SVH
`define MMCR_CONSTS_SVH
// Register indices; byte offset within the block is four times the index
`define MMCR_IDX_EE_PLACE   5'h12
`define MMCR_IDX_SYS_OPT    5'h13
`define MMCR_IDX_TEST0      5'h14
`define MMCR_IDX_TEST1      5'h17
`define MMCR_IDX_MEMSIZE    5'h1c
// Field positions
`define MMCR_EE_BASE_HI     7
`define MMCR_EE_BASE_LO     3
`define MMCR_EE_EN_BIT      0
`define MMCR_STR_HI         3
`define MMCR_STR_LO         2
`define MMCR_UPPER_BIT      1
`define MMCR_FLASH_BIT      0
// Reset values
`define MMCR_STR_RESET      2'h3
`define MMCR_RAM_PLACE_RST  8'h09
// Bus answers
`define MMCR_RESP_OKAY      2'h0
`define MMCR_RESP_SLVERR    2'h2
`endif

/* core/mmcr_memory_map_config_regs.sv */
// Memory-map configuration register bank with an AXI4-Lite slave
//
// Register access over AXI4-Lite was decided locally.
`include "mmcr_consts.svh"
module mmcr_memory_map_config_regs #(
   parameter logic [7:0] EE_PLACE_RESET  = 8'h01, // Integration choice
   parameter bit         EE_POS_ONCE     = 1'b0,  // Position write-once
   parameter logic       FLASH_EN_EXPAND = 1'b0   // Flash reset, expanded
) (
   // Clock and reset
   input  wire logic               clk,
   input  wire logic               rstn,
   // Write address channel
   input  wire logic [15:0]        awaddr,
   input  wire logic               awvalid,
   output logic                    awready,
   // Write data channel
   input  wire logic [31:0]        wdata,
   input  wire logic [3:0]         wstrb,
   input  wire logic               wvalid,
   output logic                    wready,
   // Write response channel
   output logic [1:0]              bresp,
   output logic                    bvalid,
   input  wire logic               bready,
   // Read address channel
   input  wire logic [15:0]        araddr,
   input  wire logic               arvalid,
   output logic                    arready,
   // Read data channel
   output logic [31:0]             rdata,
   output logic [1:0]              rresp,
   output logic                    rvalid,
   input  wire logic               rready,
   // Core context
   input  wire mmcr_pkg::mmcr_mode_t mode,
   input  wire logic [4:0]         reg_block_base,
   input  wire logic [4:0]         ram_placement,
   input  wire logic               ram_high_align,
   // Integration size switches at the core boundary
   input  wire logic               register_space_size,
   input  wire logic [1:0]         eeprom_space_size,
   input  wire logic [2:0]         ram_space_size,
   // Decode controls
   output logic [4:0]              eeprom_base_bits,
   output logic                    eeprom_map_enable,
   output logic [1:0]              external_stretch_count,
   output logic                    flash_upper_half_only,
   output logic                    flash_map_enable,
   output logic [15:0]             ram_base_addr
);

   ////////////////////////////////////////////////////////////////////
   // Storage
   logic [7:0] ee_place;        // Eeprom placement register
   logic [1:0] stretch;         // Stretch field
   logic       upper_only;      // Upper-half flash select
   logic       flash_en;        // Flash enable
   logic       ee_pos_done;     // Position written once
   logic       sys_opt_done;    // Option register written once
   logic       init_done;       // Mode-dependent reset applied
   logic [5:0] sw_meta;         // Switch synchroniser, first stage
   logic [5:0] sw_sync;         // Switch synchroniser, second stage
   logic       aw_held;         // Write address captured
   logic       w_held;          // Write data captured
   logic [15:0] aw_addr;        // Captured write address
   logic [7:0] w_byte;          // Captured low data byte
   logic       w_lane0;         // Captured low byte strobe

   ////////////////////////////////////////////////////////////////////
   // Mode and address decode
   wire is_special = (mode == mmcr_pkg::mmcr_special_single) ||
                     (mode == mmcr_pkg::mmcr_special_expanded) ||
                     (mode == mmcr_pkg::mmcr_special_test);
   // Single chip and peripheral: stretch has no meaning
   wire stretch_quiet = (mode == mmcr_pkg::mmcr_normal_single) ||
                        (mode == mmcr_pkg::mmcr_peripheral) ||
                        (mode == mmcr_pkg::mmcr_emul_single) ||
                        (mode == mmcr_pkg::mmcr_special_single);
   // Block hit: base bits match, offset within the word window
   wire aw_in_blk = (aw_addr[15:11] == reg_block_base) &&
                    (aw_addr[10:7] == 4'h0);
   wire ar_in_blk = (araddr[15:11] == reg_block_base) &&
                    (araddr[10:7] == 4'h0);
   wire [4:0] aw_idx = aw_addr[6:2];
   wire [4:0] ar_idx = araddr[6:2];
   wire do_wr  = aw_held && w_held && !bvalid;
   wire wr_ok  = do_wr && aw_in_blk && w_lane0;
   wire wr_ee  = wr_ok && (aw_idx == `MMCR_IDX_EE_PLACE);
   wire wr_opt = wr_ok && (aw_idx == `MMCR_IDX_SYS_OPT);
   // Position field lock; enable bit never locks
   wire ee_pos_open  = !EE_POS_ONCE || is_special || !ee_pos_done;
   wire sys_opt_open = is_special || !sys_opt_done;
   // Mapped write locations answer OKAY, the rest SLVERR
   wire aw_mapped = aw_in_blk && ((aw_idx == `MMCR_IDX_EE_PLACE) ||
                    (aw_idx == `MMCR_IDX_SYS_OPT) ||
                    (aw_idx == `MMCR_IDX_TEST0) ||
                    (aw_idx == `MMCR_IDX_TEST1) ||
                    (aw_idx == `MMCR_IDX_MEMSIZE));
   wire [7:0] opt_value = {4'h0, stretch, upper_only, flash_en};
   wire [7:0] size_value = {sw_sync[5], 1'b0, sw_sync[4:3],
                            1'b0, sw_sync[2:0]};
   // Read selection
   wire hit_ee   = ar_in_blk && (ar_idx == `MMCR_IDX_EE_PLACE);
   wire hit_opt  = ar_in_blk && (ar_idx == `MMCR_IDX_SYS_OPT);
   wire hit_tst  = ar_in_blk && ((ar_idx == `MMCR_IDX_TEST0) ||
                                 (ar_idx == `MMCR_IDX_TEST1));
   wire hit_size = ar_in_blk && (ar_idx == `MMCR_IDX_MEMSIZE);
   wire [7:0] rd_byte = hit_ee   ? {ee_place[7:3], 2'h0, ee_place[0]} :
                        hit_opt  ? opt_value :
                        hit_size ? size_value : 8'h00;
   wire rd_mapped = hit_ee || hit_opt || hit_tst || hit_size;
   // Mode-dependent flash enable at reset
   wire flash_rst = (mode == mmcr_pkg::mmcr_special_test) ? 1'b0 :
                    ((mode == mmcr_pkg::mmcr_normal_single) ||
                     (mode == mmcr_pkg::mmcr_peripheral) ||
                     (mode == mmcr_pkg::mmcr_special_single)) ? 1'b1 :
                    FLASH_EN_EXPAND;

   ////////////////////////////////////////////////////////////////////
   // Ram placement arithmetic in 2K units
   wire [2:0] ram_code = sw_sync[2:0];
   // Region size in 2K units: 1, 2, 4 or 8
   wire [4:0] region = (ram_code == 3'h0) ? 5'h01 :
                       (ram_code == 3'h1) ? 5'h02 :
                       (ram_code[2] == 1'b0) ? 5'h04 : 5'h08;
   wire [4:0] alloc = {2'h0, ram_code} + 5'h01;
   // Placement bits above the region are used
   wire [4:0] pos_used = ram_placement & ~(region - 5'h01);
   // Spare space below the array when aligned high
   wire [4:0] gap = ram_high_align ? (region - alloc) : 5'h00;
   wire [4:0] ram_units = pos_used + gap;

   ////////////////////////////////////////////////////////////////////
   // Size switch synchroniser
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sw_meta <= 6'h00;
         sw_sync <= 6'h00;
      end else begin
         sw_meta <= {register_space_size, eeprom_space_size, ram_space_size};
         sw_sync <= sw_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Eeprom placement register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ee_place    <= EE_PLACE_RESET & 8'hf9;
         ee_pos_done <= 1'b0;
      end else if (wr_ee) begin
         // Enable bit takes every write
         ee_place[`MMCR_EE_EN_BIT] <= w_byte[`MMCR_EE_EN_BIT];
         if (ee_pos_open) begin
            ee_place[`MMCR_EE_BASE_HI:`MMCR_EE_BASE_LO] <=
               w_byte[`MMCR_EE_BASE_HI:`MMCR_EE_BASE_LO];
         end
         ee_pos_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // System option register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stretch      <= `MMCR_STR_RESET;
         upper_only   <= 1'b0;
         flash_en     <= 1'b0;
         sys_opt_done <= 1'b0;
         init_done    <= 1'b0;
      end else if (!init_done) begin
         // Load the mode-dependent flash enable after release
         flash_en  <= flash_rst;
         init_done <= 1'b1;
      end else if (wr_opt && sys_opt_open) begin
         stretch      <= w_byte[`MMCR_STR_HI:`MMCR_STR_LO];
         upper_only   <= w_byte[`MMCR_UPPER_BIT];
         flash_en     <= w_byte[`MMCR_FLASH_BIT];
         sys_opt_done <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Decode outputs, one cycle behind the registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eeprom_base_bits       <= 5'h00;
         eeprom_map_enable      <= 1'b0;
         external_stretch_count <= 2'h0;
         flash_upper_half_only  <= 1'b0;
         flash_map_enable       <= 1'b0;
         ram_base_addr          <= 16'h0000;
      end else begin
         eeprom_base_bits  <= ee_place[`MMCR_EE_BASE_HI:`MMCR_EE_BASE_LO];
         eeprom_map_enable <= ee_place[`MMCR_EE_EN_BIT];
         // Stretch forced to zero where it has no effect
         external_stretch_count <= stretch_quiet ? 2'h0 : stretch;
         flash_upper_half_only  <= upper_only;
         flash_map_enable       <= flash_en;
         ram_base_addr          <= {ram_units, 11'h000};
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Write channels: address and data in either order
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         awready <= 1'b1;
         wready  <= 1'b1;
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= 16'h0000;
         w_byte  <= 8'h00;
         w_lane0 <= 1'b0;
         bvalid  <= 1'b0;
         bresp   <= `MMCR_RESP_OKAY;
      end else begin
         // Capture the address
         if (awvalid && awready) begin
            aw_addr <= awaddr;
            aw_held <= 1'b1;
            awready <= 1'b0;
         end
         // Capture the data byte
         if (wvalid && wready) begin
            w_byte  <= wdata[7:0];
            w_lane0 <= wstrb[0];
            w_held  <= 1'b1;
            wready  <= 1'b0;
         end
         // Both present: registers update, response raised
         if (do_wr) begin
            aw_held <= 1'b0;
            w_held  <= 1'b0;
            bvalid  <= 1'b1;
            bresp   <= aw_mapped ? `MMCR_RESP_OKAY : `MMCR_RESP_SLVERR;
         end
         // Response taken: reopen both channels
         if (bvalid && bready) begin
            bvalid  <= 1'b0;
            awready <= 1'b1;
            wready  <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Read channels
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         arready <= 1'b1;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `MMCR_RESP_OKAY;
      end else if (arvalid && arready) begin
         // Answer on the next edge
         arready <= 1'b0;
         rvalid  <= 1'b1;
         rdata   <= {24'h00_0000, rd_byte};
         rresp   <= rd_mapped ? `MMCR_RESP_OKAY : `MMCR_RESP_SLVERR;
      end else if (rvalid && rready) begin
         rvalid  <= 1'b0;
         arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Enable bit write reaches the decode output two edges on
   sequence s_ee_en_write;
      wr_ee;
   endsequence
   property p_ee_enable_lag;
      s_ee_en_write |-> ##2 (eeprom_map_enable == $past(w_byte[0], 2));
   endproperty
   a_ee_enable_lag: assert property (p_ee_enable_lag)
      else $error("eeprom enable did not follow the write");

   // Locked position field stays put
   property p_ee_pos_lock;
      (wr_ee && !ee_pos_open) |=> $stable(ee_place[7:3]);
   endproperty
   a_ee_pos_lock: assert property (p_ee_pos_lock)
      else $error("locked eeprom position changed");

   // Stretch output is zero in single chip and peripheral
   property p_stretch_quiet;
      stretch_quiet |=> (external_stretch_count == 2'h0);
   endproperty
   a_stretch_quiet: assert property (p_stretch_quiet)
      else $error("stretch active in a quiet mode");

   // Second option write outside special modes changes nothing
   property p_opt_once;
      (wr_opt && sys_opt_done && !is_special && init_done)
         |=> $stable(opt_value) ##1 $stable(flash_map_enable);
   endproperty
   a_opt_once: assert property (p_opt_once)
      else $error("write-once option field changed");

   // Test locations ignore writes
   property p_test_ignore;
      (wr_ok && ((aw_idx == `MMCR_IDX_TEST0) || (aw_idx == `MMCR_IDX_TEST1)))
         |=> $stable(ee_place) && $stable(opt_value);
   endproperty
   a_test_ignore: assert property (p_test_ignore)
      else $error("test location write changed state");

   // Size register returns the synchronised switches
   sequence s_size_read;
      arvalid && arready && hit_size;
   endsequence
   property p_size_read;
      s_size_read |=> rvalid && (rdata[7:0] == $past(size_value));
   endproperty
   a_size_read: assert property (p_size_read)
      else $error("size register read wrong");

   // Special test mode releases with flash disabled
   property p_flash_test_reset;
      (!init_done && mode == mmcr_pkg::mmcr_special_test)
         |=> !flash_en ##1 !flash_map_enable;
   endproperty
   a_flash_test_reset: assert property (p_flash_test_reset)
      else $error("flash enabled after special test reset");

   // Full-size ram aligned low sits on a 16K boundary
   property p_ram_full;
      (ram_code == 3'h7) |=> (ram_base_addr[13:0] == 14'h0000);
   endproperty
   a_ram_full: assert property (p_ram_full)
      else $error("full ram base misaligned");

   // 10K ram aligned high in first region starts at 0x1800
   property p_ram_high;
      (ram_code == 3'h4 && ram_high_align && ram_placement[4:3] == 2'h0)
         |=> (ram_base_addr == 16'h1800);
   endproperty
   a_ram_high: assert property (p_ram_high)
      else $error("high-aligned ram base wrong");

   // Reads outside the block answer with an error
   property p_unmapped_read;
      (arvalid && arready && !ar_in_blk) |=> (rresp == `MMCR_RESP_SLVERR);
   endproperty
   a_unmapped_read: assert property (p_unmapped_read)
      else $error("unmapped read not refused");

endmodule : mmcr_memory_map_config_regs

/* core/mmcr_pkg.sv */
// Types shared by the memory-map configuration register bank
package mmcr_pkg;
   // Operating mode of the chip
   typedef enum logic [2:0] {
      mmcr_normal_single,
      mmcr_normal_expanded,
      mmcr_peripheral,
      mmcr_emul_single,
      mmcr_emul_expanded,
      mmcr_special_single,
      mmcr_special_expanded,
      mmcr_special_test
   } mmcr_mode_t;
endpackage : mmcr_pkg

/* sim/mmcr_core_ctx_model.sv */
// Core-side context model: ram placement and register block position
module mmcr_core_ctx_model (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Loads from the bench, as core register writes would
   input  wire logic       ld_ram,
   input  wire logic       ld_reg,
   input  wire logic [7:0] ld_val,
   // Context seen by the register bank
   output logic [4:0]      reg_block_base,
   output logic [4:0]      ram_placement,
   output logic            ram_high_align
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] ram_place_q;   // Ram placement register image

   ////////////////////////////////////////////////////////////////////////////
   // Placement registers, updated right after the edge that loads them
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ram_place_q    <= 8'h09;
         reg_block_base <= 5'h00;   // Registers start at address zero
      end else begin
         if (ld_ram) begin
            ram_place_q <= ld_val;
         end
         if (ld_reg) begin
            reg_block_base <= ld_val[4:0];
         end
      end
   end

   // Position bits and high-align flag
   assign ram_placement  = ram_place_q[7:3];
   assign ram_high_align = ram_place_q[0];
endmodule : mmcr_core_ctx_model

/* sim/mmcr_memory_map_config_regs_tb_top.sv */
// Testbench of the memory-map configuration register bank
`include "mmcr_consts.svh"
module mmcr_memory_map_config_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   localparam logic [7:0] EE_RST = 8'h01;   // Placement reset choice
   localparam logic       FL_EXP = 1'b0;    // Flash reset, expanded
   logic clk, rstn, awvalid, wvalid, bready, arvalid, rready, awready, wready, arready;
   logic bvalid, rvalid, ram_high_align, register_space_size, eeprom_map_enable;
   logic flash_upper_half_only, flash_map_enable, ld_ram, ld_reg;
   logic [15:0] awaddr, araddr, ram_base_addr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp, eeprom_space_size, external_stretch_count;
   logic [4:0]  reg_block_base, ram_placement, eeprom_base_bits, cur_base;
   logic [2:0]  ram_space_size;
   logic [7:0]  ld_val;
   mmcr_pkg::mmcr_mode_t mode;
   int n_mismatch, comparisons;
   logic [7:0] pl_tab [3] = '{8'h09, 8'h48, 8'h49};   // Ram placement cases

   ////////////////////////////////////////////////////////////////////////////
   // Design, core context model and clock
   mmcr_memory_map_config_regs #(.EE_PLACE_RESET(EE_RST), .EE_POS_ONCE(1'b0),
      .FLASH_EN_EXPAND(FL_EXP)) mmcr_memory_map_config_regs_i (.*);
   mmcr_core_ctx_model mmcr_core_ctx_model_i (.clk(clk), .rstn(rstn), .ld_ram(ld_ram),
      .ld_reg(ld_reg), .ld_val(ld_val), .reg_block_base(reg_block_base),
      .ram_placement(ram_placement), .ram_high_align(ram_high_align));
   always #5 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Checking and closing
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : end_of_test

   // Byte address of a register index at the current block base
   function automatic logic [15:0] ad(input logic [4:0] i);
      return {cur_base, 11'h000} | 16'({i, 2'b00});
   endfunction : ad

   // Expected ram start from size code and placement image
   function automatic logic [15:0] ram_exp(input logic [2:0] sw, input logic [7:0] pl);
      logic [4:0] reg_u;
      logic [4:0] b;
      reg_u = (sw == 3'h0) ? 5'h1 : (sw == 3'h1) ? 5'h2 : (sw < 3'h4) ? 5'h4 : 5'h8;
      b = pl[7:3] & ~(reg_u - 5'h1);
      if (pl[0]) begin
         b = b + reg_u - 5'(sw) - 5'h1;   // Gap placed below the array
      end
      return {b, 11'h000};
   endfunction : ram_exp

   ////////////////////////////////////////////////////////////////////////////
   // Bus tasks: each channel held until its ready is sampled high
   task automatic axw(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
                      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a; wdata <= d; wstrb <= s;
      awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (bvalid !== 1'b1 && n < 40);
      r = bresp;
      bready <= 1'b0;
      chk(32'(n < 40), 32'h1);   // Answer arrived in time
   endtask : axw

   task automatic axr(input logic [15:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arready) arvalid <= 1'b0;
      end while (rvalid !== 1'b1 && n < 40);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      chk(32'(n < 40), 32'h1);   // Answer arrived in time
   endtask : axr

   task automatic wr(input logic [4:0] i, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] r;
      axw(ad(i), d, 4'hf, r);
      chk(32'(r), 32'(er));
      // Decode outputs launch at the edge that ends the response; look one edge later
      @(posedge clk);
   endtask : wr

   task automatic rd(input logic [4:0] i, input logic [31:0] ed, input logic [1:0] er);
      logic [31:0] d;
      logic [1:0]  r;
      axr(ad(i), d, r);
      chk(32'(r), 32'(er));
      if (er == `MMCR_RESP_OKAY) chk(d, ed);
   endtask : rd

   // Reset in a given mode, then let the decode outputs settle
   task automatic rst(input mmcr_pkg::mmcr_mode_t m);
      @(posedge clk);
      mode <= m; rstn <= 1'b0; cur_base = 5'h00;
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask : rst

   // Core context load through the model
   task automatic ld(input logic rm, input logic [7:0] v);
      @(posedge clk);
      ld_ram <= rm; ld_reg <= ~rm; ld_val <= v;
      @(posedge clk);
      ld_ram <= 1'b0; ld_reg <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : ld

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog against a hung handshake
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      logic [1:0] r;
      logic       fl;
      clk = 0; rstn = 0; awvalid = 0; wvalid = 0; bready = 0; arvalid = 0; rready = 0;
      awaddr = '0; araddr = '0; wdata = '0; wstrb = '0; ld_ram = 0; ld_reg = 0; ld_val = '0;
      register_space_size = 0; eeprom_space_size = '0; ram_space_size = '0;
      mode = mmcr_pkg::mmcr_normal_expanded; cur_base = '0;
      n_mismatch = 0; comparisons = 0;
      // Reset values in every mode
      for (int m = 0; m < 8; m++) begin
         rst(mmcr_pkg::mmcr_mode_t'(m));
         fl = (m == 0 || m == 2 || m == 5) ? 1'b1 : (m == 7) ? 1'b0 : FL_EXP;
         rd(`MMCR_IDX_SYS_OPT, {28'h0, 3'b110, fl}, `MMCR_RESP_OKAY);
         chk(32'(flash_map_enable), 32'(fl));
         rd(`MMCR_IDX_EE_PLACE, 32'(EE_RST & 8'hf9), `MMCR_RESP_OKAY);
         chk(32'(eeprom_map_enable), 32'(EE_RST[0]));
         chk(32'(external_stretch_count), (m == 0 || m == 2 || m == 3 || m == 5) ? 32'h0 : 32'h3);
      end
      // Option register in normal expanded mode: write once only
      rst(mmcr_pkg::mmcr_normal_expanded);
      chk(32'(external_stretch_count), 32'h3);
      wr(`MMCR_IDX_SYS_OPT, 32'hffffff06, `MMCR_RESP_OKAY);
      chk(32'(external_stretch_count), 32'h1);
      chk(32'(flash_upper_half_only), 32'h1);
      chk(32'(flash_map_enable), 32'h0);
      rd(`MMCR_IDX_SYS_OPT, 32'h06, `MMCR_RESP_OKAY);
      wr(`MMCR_IDX_SYS_OPT, 32'h0b, `MMCR_RESP_OKAY);
      rd(`MMCR_IDX_SYS_OPT, 32'h06, `MMCR_RESP_OKAY);
      // Stretch has no effect in single chip and peripheral modes
      for (int m = 0; m < 3; m++) begin
         @(posedge clk);
         mode <= (m == 2) ? mmcr_pkg::mmcr_normal_expanded :
                 (m == 1) ? mmcr_pkg::mmcr_peripheral : mmcr_pkg::mmcr_normal_single;
         repeat (3) @(posedge clk);
         chk(32'(external_stretch_count), (m == 2) ? 32'h1 : 32'h0);
      end
      // Eeprom placement: position and enable writable any number of times
      wr(`MMCR_IDX_EE_PLACE, 32'hff, `MMCR_RESP_OKAY);
      chk(32'(eeprom_base_bits), 32'h1f);
      chk(32'(eeprom_map_enable), 32'h1);
      rd(`MMCR_IDX_EE_PLACE, 32'hf9, `MMCR_RESP_OKAY);
      wr(`MMCR_IDX_EE_PLACE, 32'h12, `MMCR_RESP_OKAY);
      chk(32'(eeprom_base_bits), 32'h02);
      chk(32'(eeprom_map_enable), 32'h0);
      axw(ad(`MMCR_IDX_EE_PLACE), 32'hff, 4'he, r);   // Low byte not strobed
      chk(32'(r), 32'(`MMCR_RESP_OKAY));
      rd(`MMCR_IDX_EE_PLACE, 32'h10, `MMCR_RESP_OKAY);
      // Size switches and ram start for three placement images
      for (int p = 0; p < 3; p++) begin
         ld(1'b1, pl_tab[p]);
         for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            register_space_size <= i[0]; eeprom_space_size <= i[1:0]; ram_space_size <= i[2:0];
            repeat (4) @(posedge clk);
            rd(`MMCR_IDX_MEMSIZE, {24'h0, i[0], 1'b0, i[1:0], 1'b0, i[2:0]},
               `MMCR_RESP_OKAY);
            chk(32'(ram_base_addr), 32'(ram_exp(i[2:0], pl_tab[p])));
         end
      end
      // Test and size locations ignore writes
      wr(`MMCR_IDX_TEST0, 32'hff, `MMCR_RESP_OKAY);
      rd(`MMCR_IDX_TEST0, 32'h0, `MMCR_RESP_OKAY);
      wr(`MMCR_IDX_TEST1, 32'hff, `MMCR_RESP_OKAY);
      rd(`MMCR_IDX_TEST1, 32'h0, `MMCR_RESP_OKAY);
      wr(`MMCR_IDX_MEMSIZE, 32'h00, `MMCR_RESP_OKAY);
      rd(`MMCR_IDX_MEMSIZE, 32'hb7, `MMCR_RESP_OKAY);
      // Unmapped index and an address outside the block
      rd(5'h15, 32'h0, `MMCR_RESP_SLVERR);
      wr(5'h15, 32'hff, `MMCR_RESP_SLVERR);
      axw(ad(`MMCR_IDX_SYS_OPT) | 16'h0080, 32'h0, 4'hf, r);
      chk(32'(r), 32'(`MMCR_RESP_SLVERR));
      // Relocated register block moves the eeprom placement register
      ld(1'b0, 8'h03);
      cur_base = 5'h03;
      rd(`MMCR_IDX_EE_PLACE, 32'h10, `MMCR_RESP_OKAY);
      cur_base = 5'h00;
      rd(`MMCR_IDX_EE_PLACE, 32'h0, `MMCR_RESP_SLVERR);
      // Special test mode: option writable again and again, every stretch code
      rst(mmcr_pkg::mmcr_special_test);
      for (int s = 0; s < 4; s++) begin
         wr(`MMCR_IDX_SYS_OPT, 32'({s[1:0], 2'b01}), `MMCR_RESP_OKAY);
         chk(32'(external_stretch_count), 32'(s));
         chk(32'(flash_map_enable), 32'h1);
      end
      end_of_test();
   end
endmodule : mmcr_memory_map_config_regs_tb_top
